// ### src/omc_pkg.sv
// shared constants and types for the operating mode controller
package omc_pkg;
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned RST_PULSE_US  = 1000;
  localparam int unsigned NREQ_TMO_MS   = 150;
  localparam int unsigned RST_PULSE_CYC = (CLK_HZ / 1_000_000) * RST_PULSE_US;
  localparam int unsigned NREQ_TMO_CYC  = (CLK_HZ / 1000) * NREQ_TMO_MS;
  localparam int unsigned CS_PERIOD_CYC = 40_000;
  localparam int unsigned CS_ON_CYC     = 400;

  // two mode-select bits of the mode control register
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_SLEEP  = 2'h1;
  localparam logic [1:0] MODE_STOP   = 2'h2;
  localparam logic [1:0] MODE_RSVD   = 2'h3;

  // analog mux selections
  localparam logic [2:0] AMUX_BATTERY_SENSE_INPUT = 3'h0;
  localparam logic [2:0] AMUX_L1     = 3'h1;
  localparam logic [2:0] AMUX_TEMP   = 3'h5;

  typedef enum logic [4:0] {
    ST_RESET = 5'b0_0001,
    ST_NREQ  = 5'b0_0010,
    ST_NORM  = 5'b0_0100,
    ST_STOP  = 5'b0_1000,
    ST_SLEEP = 5'b1_0000
  } omc_state_t;

  typedef struct packed {
    logic       hs1_on;
    logic       hs2_on;
    logic       ls1_on;
    logic       ls2_on;
    logic       hs1_pwm;
    logic       hs2_pwm;
    logic       ls1_pwm;
    logic       ls2_pwm;
    logic       sensor_supply_on;
    logic       cyclic_sense_en;
    logic       cyclic_sense_hs2;
    logic [2:0] amux_sel;
  } omc_ctrl_t;

  typedef struct packed {
    logic vs_ov;
    logic vs_uv;
    logic tsd;
    logic tpw;
  } omc_fault_t;

  typedef struct packed {
    logic       main_reg_on;
    logic       main_reg_limited;
    logic       lin_tx_en;
    logic       lin_rx_en;
    logic       wdog_window_en;
    logic       hs1;
    logic       hs2;
    logic       ls1;
    logic       ls2;
    logic       sensor_supply_out;
    logic [2:0] mux_analog_sel;
  } omc_out_t;
endpackage

// ### src/omc_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module omc_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // data
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q;
  logic [WIDTH-1:0] out_d;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("omc_sync: width must be at least one");
  end

  always_comb
  begin
    // stage 1 read only by stage 2; output changes when stages 2 and 3 agree
    out_d = out_q;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (s2_q[i] == s3_q[i])
      begin
        out_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_q  <= INIT;
      s2_q  <= INIT;
      s3_q  <= INIT;
      out_q <= INIT;
    end
    else
    begin
      s1_q  <= din;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end

  assign dout = out_q;
endmodule
`default_nettype wire

// ### src/omc_mode_ctrl.sv
// operating mode sequencer of the system basis chip
// Operation
// - power-up holds reset low 1ms, then normal request
// - vdd low, watchdog fail, wake, timeout give reset
// - normal request after reset and stop wake-up
// - normal request: regulator on, reset high, lin rx
// - normal request starts 150 ms timer
// - no normal command before timeout gives reset
// - watchdog config grounded skips normal request
// - config open stays 150 ms before normal
// - window watchdog only with resistor config
// - sleep only by one spi write from normal
// - sleep: regulator off, wake inputs and lin rx
// - cyclic sense pulses high side, samples inputs
// - sleep wake acts as power-up, keeps source
// - mode chosen by two mode-select bits
// - normal: sensor supply follows its setting
// - normal: ov, uv, shutdown, prewarning interrupts
// - stop wake-up raises wake interrupt
// - normal: inputs read digital or via mux
// - normal: switches follow spi, pwm optional
// - all exchange over 8-bit spi transfers
// - battery sense selectable onto analog mux
// - stop only entered by spi command
// - stop wake: normal request and irq, except cs/reset
`timescale 1ns/1ps
`default_nettype none
module omc_mode_ctrl #(
  parameter int unsigned RST_PULSE_CYC = omc_pkg::RST_PULSE_CYC,
  parameter int unsigned NREQ_TMO_CYC  = omc_pkg::NREQ_TMO_CYC,
  parameter int unsigned CS_PERIOD_CYC = omc_pkg::CS_PERIOD_CYC,
  parameter int unsigned CS_ON_CYC     = omc_pkg::CS_ON_CYC
) (
  // clock and power-up reset
  input  wire logic              clk,
  input  wire logic              rst,
  // decoded spi writes from the 8-bit spi slave: one-cycle strobes, mode bits and held settings
  input  wire logic              mode_control_reg_wr,
  input  wire logic [1:0]        mode_select_bits,
  input  wire logic              timing_control_reg_wr,
  input  wire omc_pkg::omc_ctrl_t ctrl,
  input  wire logic              irq_ack,
  // supervisors, same clock
  input  wire logic              vdd_low,
  input  wire logic              wdog_fail,
  input  wire omc_pkg::omc_fault_t faults,
  // pins
  input  wire logic [1:0]        watchdog_config_input,
  input  wire logic [3:0]        multipurpose_inputs,
  input  wire logic              pwm_input,
  input  wire logic              lin_wake,
  input  wire logic              forced_wake,
  input  wire logic              cs_n,
  input  wire logic              ext_rst_n,
  // outputs
  output omc_pkg::omc_state_t    mode,
  output omc_pkg::omc_out_t      outs,
  output logic [3:0]             mp_in_level,
  output logic                   rst_out_n,
  output logic                   irq_n,
  output logic                   wake_pending,
  output logic                   battery_fail_flag
);
  localparam int unsigned CW = $clog2(NREQ_TMO_CYC + RST_PULSE_CYC + CS_PERIOD_CYC + 2);
  if (RST_PULSE_CYC < 1 || NREQ_TMO_CYC < 1 || CS_ON_CYC < 1 || CS_ON_CYC >= CS_PERIOD_CYC)
  begin : g_bad_timing
    $error("omc_mode_ctrl: bad timing parameters");
  end

  // synchronised pins; config code 0 grounded, 1 resistor, 2 open
  logic [1:0] wdc;
  logic [3:0] lx;
  logic       pwm, linw, fwk, cs_s, erst_s;
  // reset image: config open, select and reset lines released
  omc_sync #(.WIDTH(11), .INIT(11'h403)) u_sync (
    .clk  (clk),
    .rst  (rst),
    .din  ({watchdog_config_input, multipurpose_inputs, pwm_input, lin_wake,
            forced_wake, cs_n, ext_rst_n}),
    .dout ({wdc, lx, pwm, linw, fwk, cs_s, erst_s})
  );

  omc_pkg::omc_state_t st_q, st_d;
  logic [CW-1:0] tmr_q, tmr_d;
  logic [CW-1:0] cyc_q, cyc_d;
  logic [3:0]    lx_ref_q, lx_ref_d;
  logic          cs_prev_q, cs_prev_d;
  logic          erst_prev_q, erst_prev_d;
  logic          irq_q, irq_d;
  logic          irq_n_q, irq_n_d;
  logic          wake_q, wake_d;
  logic          bf_q, bf_d;
  logic          rsto_q, rsto_d;
  omc_pkg::omc_out_t out_q, out_d;
  logic [3:0]    lvl_q, lvl_d;
  logic          cs_on, wake_ev, stop_irq_wake, stop_quiet_wake, fault_irq;

  always_comb
  begin
    st_d          = st_q;
    tmr_d         = tmr_q;
    cyc_d         = cyc_q;
    lx_ref_d      = lx_ref_q;
    cs_prev_d     = cs_s;
    erst_prev_d   = erst_s;
    irq_d         = irq_q;
    wake_d        = wake_q;
    bf_d          = bf_q;
    rsto_d        = rsto_q;
    out_d         = '0;
    lvl_d         = lvl_q;
    // cyclic sense timing from the low-power oscillator stand-in
    cs_on         = ctrl.cyclic_sense_en && (cyc_q < CW'(CS_ON_CYC));
    // with cyclic sense, inputs are compared only during the on-time
    wake_ev       = linw || fwk ||
                    ((lx != lx_ref_q) && (!ctrl.cyclic_sense_en || cs_on));
    stop_irq_wake = wake_ev;
    stop_quiet_wake = (cs_s && !cs_prev_q) || (!erst_s && erst_prev_q);
    fault_irq     = faults.vs_ov || faults.vs_uv || faults.tsd || faults.tpw;
    if (ctrl.cyclic_sense_en)
    begin
      cyc_d = (cyc_q >= CW'(CS_PERIOD_CYC - 1)) ? '0 : cyc_q + 1'b1;
    end
    else
    begin
      cyc_d = '0;
    end
    case (st_q)
      omc_pkg::ST_RESET:
      begin
        rsto_d = 1'b0;
        out_d.main_reg_on = 1'b1;
        // reset pulse counts only once the external line is released
        if (!erst_s || vdd_low)
        begin
          tmr_d = '0;
        end
        else if (tmr_q >= CW'(RST_PULSE_CYC - 1))
        begin
          tmr_d  = '0;
          rsto_d = 1'b1;
          st_d   = (wdc == 2'h0) ? omc_pkg::ST_NORM : omc_pkg::ST_NREQ;
        end
        else
        begin
          tmr_d = tmr_q + 1'b1;
        end
      end
      omc_pkg::ST_NREQ:
      begin
        out_d.main_reg_on = 1'b1;
        out_d.lin_rx_en   = 1'b1;
        rsto_d = 1'b1;
        tmr_d  = tmr_q + 1'b1;
        if (vdd_low || !erst_s)
        begin
          st_d = omc_pkg::ST_RESET;
          tmr_d = '0;
        end
        else if (mode_control_reg_wr && mode_select_bits == omc_pkg::MODE_NORMAL)
        begin
          st_d = omc_pkg::ST_NORM;
          tmr_d = '0;
        end
        else if (tmr_q >= CW'(NREQ_TMO_CYC - 1))
        begin
          tmr_d = '0;
          // open config lets the timer carry on into normal
          st_d  = (wdc == 2'h2) ? omc_pkg::ST_NORM : omc_pkg::ST_RESET;
          rsto_d = (wdc == 2'h2);
        end
      end
      omc_pkg::ST_NORM:
      begin
        out_d.main_reg_on       = 1'b1;
        out_d.lin_rx_en         = 1'b1;
        out_d.lin_tx_en         = 1'b1;
        out_d.wdog_window_en    = (wdc == 2'h1);
        out_d.sensor_supply_out = ctrl.sensor_supply_on;
        out_d.hs1 = ctrl.hs1_on && (!ctrl.hs1_pwm || pwm);
        out_d.hs2 = ctrl.hs2_on && (!ctrl.hs2_pwm || pwm);
        out_d.ls1 = ctrl.ls1_on && (!ctrl.ls1_pwm || pwm);
        out_d.ls2 = ctrl.ls2_on && (!ctrl.ls2_pwm || pwm);
        out_d.mux_analog_sel = ctrl.amux_sel;
        // an input routed to the mux reads as zero digitally
        for (int i = 0; i < 4; i++)
        begin
          lvl_d[i] = lx[i] && (ctrl.amux_sel != 3'(omc_pkg::AMUX_L1 + 3'(i)));
        end
        if (fault_irq)
        begin
          irq_d = 1'b1;
        end
        lx_ref_d = lx;
        if (vdd_low || wdog_fail || !erst_s)
        begin
          st_d = omc_pkg::ST_RESET;
          tmr_d = '0;
        end
        else if (mode_control_reg_wr && mode_select_bits == omc_pkg::MODE_SLEEP)
        begin
          st_d = omc_pkg::ST_SLEEP;
        end
        else if (mode_control_reg_wr && mode_select_bits == omc_pkg::MODE_STOP)
        begin
          st_d = omc_pkg::ST_STOP;
        end
      end
      omc_pkg::ST_STOP:
      begin
        out_d.main_reg_on      = 1'b1;
        out_d.main_reg_limited = 1'b1;
        out_d.lin_rx_en        = 1'b1;
        out_d.hs1 = cs_on && !ctrl.cyclic_sense_hs2;
        out_d.hs2 = cs_on && ctrl.cyclic_sense_hs2;
        if (vdd_low)
        begin
          st_d = omc_pkg::ST_RESET;
          tmr_d = '0;
        end
        else if (stop_quiet_wake)
        begin
          st_d = omc_pkg::ST_NREQ;
          tmr_d = '0;
        end
        else if (stop_irq_wake)
        begin
          st_d   = omc_pkg::ST_NREQ;
          tmr_d  = '0;
          irq_d  = 1'b1;
          wake_d = 1'b1;
        end
      end
      omc_pkg::ST_SLEEP:
      begin
        // regulator off; only wake sources and lin receiver live
        out_d.lin_rx_en = 1'b1;
        out_d.hs1 = cs_on && !ctrl.cyclic_sense_hs2;
        out_d.hs2 = cs_on && ctrl.cyclic_sense_hs2;
        rsto_d = 1'b0;
        if (wake_ev)
        begin
          st_d   = omc_pkg::ST_RESET;
          tmr_d  = '0;
          wake_d = 1'b1;
          bf_d   = 1'b0;
        end
      end
      default:
      begin
        st_d = omc_pkg::ST_RESET;
        tmr_d = '0;
      end
    endcase
    // a new interrupt in the ack cycle wins; none while reset is low
    if (irq_ack && !(st_q == omc_pkg::ST_NORM && fault_irq) && !(irq_d && !irq_q)
        && !(wake_d && !wake_q))
    begin
      irq_d  = 1'b0;
      wake_d = 1'b0;
      bf_d   = 1'b0;
    end
    // reset output falls on the very edge that enters reset mode
    if (st_d == omc_pkg::ST_RESET)
    begin
      rsto_d = 1'b0;
    end
    if (!rsto_q || !rsto_d)
    begin
      irq_d = 1'b0;
    end
    irq_n_d = !irq_d;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_q        <= omc_pkg::ST_RESET;
      tmr_q       <= '0;
      cyc_q       <= '0;
      lx_ref_q    <= '0;
      cs_prev_q   <= 1'b1;
      erst_prev_q <= 1'b1;
      irq_q       <= 1'b0;
      irq_n_q     <= 1'b1;
      wake_q      <= 1'b0;
      bf_q        <= 1'b1;
      rsto_q      <= 1'b0;
      out_q       <= '0;
      lvl_q       <= '0;
    end
    else
    begin
      st_q        <= st_d;
      tmr_q       <= tmr_d;
      cyc_q       <= cyc_d;
      lx_ref_q    <= lx_ref_d;
      cs_prev_q   <= cs_prev_d;
      erst_prev_q <= erst_prev_d;
      irq_q       <= irq_d;
      irq_n_q     <= irq_n_d;
      wake_q      <= wake_d;
      bf_q        <= bf_d;
      rsto_q      <= rsto_d;
      out_q       <= out_d;
      lvl_q       <= lvl_d;
    end
  end

  assign mode              = st_q;
  assign outs              = out_q;
  assign mp_in_level       = lvl_q;
  assign rst_out_n         = rsto_q;
  assign irq_n             = irq_n_q;
  assign wake_pending      = wake_q;
  assign battery_fail_flag = bf_q;
endmodule
`default_nettype wire

// ### test/omc_mode_ctrl_props.sv
// port assertions for the operating mode controller
`timescale 1ns/1ps
`default_nettype none
module omc_mode_ctrl_props #(
  parameter int unsigned RST_PULSE_CYC = 20,
  parameter int unsigned NREQ_TMO_CYC  = 100
) (
  // clock and reset
  input wire logic                clk,
  input wire logic                rst,
  // causes
  input wire logic                mode_control_reg_wr,
  input wire logic [1:0]          mode_select_bits,
  input wire logic                vdd_low,
  input wire logic                wdog_fail,
  input wire logic [1:0]          watchdog_config_input,
  // effects
  input wire omc_pkg::omc_state_t mode,
  input wire omc_pkg::omc_out_t   outs,
  input wire logic                rst_out_n
);
  int unsigned rcnt_q;
  int unsigned rcnt_d;
  int unsigned ncnt_q;
  int unsigned ncnt_d;
  logic        wr_ok;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // supervisor faults outrank a mode write
  assign wr_ok = mode_control_reg_wr && !vdd_low && !wdog_fail;
  always_comb
  begin
    // only cycles of reset mode count; a low supply restarts the pulse
    rcnt_d = (mode == omc_pkg::ST_RESET && !vdd_low) ? rcnt_q + 1 : 0;
    ncnt_d = (mode == omc_pkg::ST_NREQ) ? ncnt_q + 1 : 0;
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rcnt_q <= 0;
      ncnt_q <= 0;
    end
    else
    begin
      rcnt_q <= rcnt_d;
      ncnt_q <= ncnt_d;
    end
  end
  a_reset_holds_low: assert property (mode == omc_pkg::ST_RESET |-> !rst_out_n)
    else $error("reset output released in reset mode");
  // upper bound leaves room for the pin synchronisers
  a_pulse_length: assert property ($rose(rst_out_n) |->
    rcnt_q >= RST_PULSE_CYC - 1 && rcnt_q <= RST_PULSE_CYC + 8)
    else $error("reset pulse length wrong");
  a_nreq_outputs: assert property (mode == omc_pkg::ST_NREQ |-> rst_out_n
    ##1 (outs.main_reg_on && !outs.lin_tx_en))
    else $error("normal request outputs wrong");
  a_nreq_bound: assert property (mode == omc_pkg::ST_NREQ |-> ncnt_q <= NREQ_TMO_CYC + 1)
    else $error("normal request overstays timer");
  a_normal_cmd: assert property (mode == omc_pkg::ST_NREQ && wr_ok
    && mode_select_bits == omc_pkg::MODE_NORMAL |=> mode == omc_pkg::ST_NORM)
    else $error("normal command not taken");
  a_sleep_cmd: assert property (mode == omc_pkg::ST_NORM && wr_ok
    && mode_select_bits == omc_pkg::MODE_SLEEP |=> mode == omc_pkg::ST_SLEEP)
    else $error("sleep command not taken");
  a_rsvd_ignored: assert property (mode == omc_pkg::ST_NORM && wr_ok
    && mode_select_bits == omc_pkg::MODE_RSVD |=> mode == omc_pkg::ST_NORM)
    else $error("reserved mode code acted on");
  a_vdd_reset: assert property (vdd_low |=> mode == omc_pkg::ST_RESET)
    else $error("low supply did not reset");
  a_sleep_reg_off: assert property (mode == omc_pkg::ST_SLEEP |=> !outs.main_reg_on)
    else $error("regulator on in sleep");
  a_sleep_wake: assert property (mode == omc_pkg::ST_SLEEP ##1 mode != omc_pkg::ST_SLEEP
    |-> mode == omc_pkg::ST_RESET)
    else $error("sleep left other than to reset");
  a_window_cfg: assert property (outs.wdog_window_en |-> watchdog_config_input == 2'h1)
    else $error("window watchdog without resistor");
  c_normal: cover property ($rose(mode == omc_pkg::ST_NORM));
  c_sleep: cover property ($rose(mode == omc_pkg::ST_SLEEP));
  c_stop: cover property ($rose(mode == omc_pkg::ST_STOP));
endmodule
`default_nettype wire

// ### test/omc_mcu_model.sv
// controller side: decoded spi writes and irq acknowledge
`timescale 1ns/1ps
`default_nettype none
module omc_mcu_model (
  // clock
  input  wire logic  clk,
  // decoded spi strobes
  output logic       mode_control_reg_wr,
  output logic [1:0] mode_select_bits,
  output logic       timing_control_reg_wr,
  output logic       irq_ack
);
  initial
  begin
    mode_control_reg_wr = 1'h0;
    mode_select_bits = 2'h3;
    timing_control_reg_wr = 1'h0;
    irq_ack = 1'h0;
  end
  // one 8-bit transfer ends as a one-cycle strobe
  task automatic wr_mode(input logic [1:0] bits);
    @(negedge clk);
    mode_select_bits = bits;
    mode_control_reg_wr = 1'h1;
    @(negedge clk);
    mode_control_reg_wr = 1'h0;
    mode_select_bits = ~bits;
  endtask
  // timing register first, then both mode bits zero
  task automatic req_normal();
    @(negedge clk);
    timing_control_reg_wr = 1'h1;
    @(negedge clk);
    timing_control_reg_wr = 1'h0;
    wr_mode(omc_pkg::MODE_NORMAL);
  endtask
  task automatic ack();
    @(negedge clk);
    irq_ack = 1'h1;
    @(negedge clk);
    irq_ack = 1'h0;
  endtask
endmodule
`default_nettype wire

// ### test/omc_mode_ctrl_bench.sv
// self-checking bench of the operating mode controller
`timescale 1ns/1ps
`default_nettype none
module omc_mode_ctrl_bench;
  localparam int unsigned RP = 20;
  localparam int unsigned NT = 100;
  logic                clk;
  logic                rst;
  logic                vdd_low;
  logic                lin_wake;
  logic                forced_wake;
  logic                cs_n;
  logic                wdog_fail;
  logic                ext_rst_n;
  logic [3:0]          mp_in;
  logic [3:0]          mp_in_level;
  logic [1:0]          watchdog_config_input;
  logic                mode_control_reg_wr;
  logic [1:0]          mode_select_bits;
  logic                timing_control_reg_wr;
  logic                irq_ack;
  logic                rst_out_n;
  logic                irq_n;
  logic                wake_pending;
  logic                battery_fail_flag;
  omc_pkg::omc_ctrl_t  ctrl;
  omc_pkg::omc_fault_t faults;
  omc_pkg::omc_state_t mode;
  omc_pkg::omc_out_t   outs;
  int                  n_mismatch = 0;
  int                  n_tests = 0;
  int                  n;
  initial clk = 1'h0;
  always #12.5 clk = ~clk;
  omc_mode_ctrl #(.RST_PULSE_CYC(RP), .NREQ_TMO_CYC(NT), .CS_PERIOD_CYC(50), .CS_ON_CYC(5))
  u_dut (.clk, .rst, .mode_control_reg_wr, .mode_select_bits, .timing_control_reg_wr, .ctrl,
    .irq_ack, .vdd_low, .wdog_fail, .faults, .watchdog_config_input,
    .multipurpose_inputs(mp_in), .pwm_input(1'h0), .lin_wake, .forced_wake, .cs_n,
    .ext_rst_n, .mode, .outs, .mp_in_level, .rst_out_n, .irq_n, .wake_pending,
    .battery_fail_flag);
  omc_mcu_model u_mcu (.clk, .mode_control_reg_wr, .mode_select_bits,
    .timing_control_reg_wr, .irq_ack);
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk_bit(input logic g, input logic e, input string m);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic chk_mode(input omc_pkg::omc_state_t e);
    chk_bit(mode === e, 1'h1, "mode");
  endtask
  // bounded wait, sampled at the settled falling edge
  task automatic wait_mode(input omc_pkg::omc_state_t e, input int lim);
    n = 0;
    while (mode !== e && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    chk_mode(e);
  endtask
  task automatic power_up(input logic [1:0] c, input omc_pkg::omc_state_t e);
    @(negedge clk);
    rst = 1'h1;
    watchdog_config_input = c;
    repeat (2) @(negedge clk);
    rst = 1'h0;
    chk_bit(rst_out_n, 1'h0, "reset out high");
    wait_mode(e, RP + 20);
    chk_bit(n >= RP - 1, 1'h1, "reset pulse short");
    chk_bit(rst_out_n, 1'h1, "reset out low");
  endtask
  task automatic t_normal();
    power_up(2'h1, omc_pkg::ST_NREQ);
    u_mcu.wr_mode(omc_pkg::MODE_SLEEP);
    chk_mode(omc_pkg::ST_NREQ);
    chk_bit(outs.lin_tx_en, 1'h0, "lin tx in request");
    u_mcu.req_normal();
    chk_mode(omc_pkg::ST_NORM);
    u_mcu.wr_mode(omc_pkg::MODE_RSVD);
    chk_mode(omc_pkg::ST_NORM);
    chk_bit(outs.wdog_window_en, 1'h1, "window off");
    chk_bit(outs.sensor_supply_out, 1'h1, "sensor supply");
    chk_bit(outs.mux_analog_sel === omc_pkg::AMUX_BATTERY_SENSE_INPUT, 1'h1, "mux");
    mp_in = 4'h5;
    repeat (6) @(negedge clk);
    chk_bit(mp_in_level === 4'h5, 1'h1, "input levels");
    ctrl.amux_sel = omc_pkg::AMUX_L1;
    repeat (2) @(negedge clk);
    chk_bit(mp_in_level === 4'h4, 1'h1, "routed input not masked");
    ctrl.amux_sel = omc_pkg::AMUX_BATTERY_SENSE_INPUT;
    ctrl.ls1_on = 1'h1;
    ctrl.hs1_on = 1'h1;
    ctrl.hs1_pwm = 1'h1;
    @(negedge clk);
    chk_bit(outs.ls1, 1'h1, "low side off");
    chk_bit(outs.hs1, 1'h0, "high side ignores pwm");
    faults.tsd = 1'h1;
    repeat (2) @(negedge clk);
    chk_bit(irq_n, 1'h0, "no fault irq");
    faults = '0;
    u_mcu.ack();
    chk_bit(irq_n, 1'h1, "irq not acknowledged");
    wdog_fail = 1'h1;
    @(negedge clk);
    wdog_fail = 1'h0;
    chk_mode(omc_pkg::ST_RESET);
    chk_bit(rst_out_n, 1'h0, "reset out high after fail");
  endtask
  task automatic t_timeout(input logic [1:0] c, input omc_pkg::omc_state_t e);
    power_up(c, omc_pkg::ST_NREQ);
    wait_mode(e, NT + 20);
    chk_bit(n >= NT - 2, 1'h1, "timer short");
  endtask
  task automatic t_sleep();
    power_up(2'h0, omc_pkg::ST_NORM);
    ctrl.cyclic_sense_en = 1'h1;
    u_mcu.wr_mode(omc_pkg::MODE_SLEEP);
    chk_mode(omc_pkg::ST_SLEEP);
    @(negedge clk);
    chk_bit(outs.main_reg_on, 1'h0, "regulator on");
    n = 0;
    while (outs.hs1 !== 1'h1 && n < 70)
    begin
      @(negedge clk);
      n++;
    end
    chk_bit(outs.hs1, 1'h1, "no sense pulse");
    forced_wake = 1'h1;
    wait_mode(omc_pkg::ST_RESET, 20);
    forced_wake = 1'h0;
    watchdog_config_input = 2'h1;
    ctrl.cyclic_sense_en = 1'h0;
    chk_bit(battery_fail_flag, 1'h0, "battery fail set");
    chk_bit(wake_pending, 1'h1, "wake source lost");
  endtask
  task automatic t_stop();
    wait_mode(omc_pkg::ST_NREQ, RP + 20);
    u_mcu.req_normal();
    u_mcu.ack();
    u_mcu.wr_mode(omc_pkg::MODE_STOP);
    chk_mode(omc_pkg::ST_STOP);
    lin_wake = 1'h1;
    wait_mode(omc_pkg::ST_NREQ, 20);
    lin_wake = 1'h0;
    repeat (2) @(negedge clk);
    chk_bit(irq_n, 1'h0, "no wake irq");
    u_mcu.ack();
    u_mcu.req_normal();
    u_mcu.wr_mode(omc_pkg::MODE_STOP);
    cs_n = 1'h0;
    repeat (6) @(negedge clk);
    cs_n = 1'h1;
    wait_mode(omc_pkg::ST_NREQ, 20);
    repeat (2) @(negedge clk);
    chk_bit(irq_n, 1'h1, "irq on select wake");
    vdd_low = 1'h1;
    @(negedge clk);
    vdd_low = 1'h0;
    chk_mode(omc_pkg::ST_RESET);
  endtask
  initial
  begin
    rst = 1'h1;
    vdd_low = 1'h0;
    lin_wake = 1'h0;
    forced_wake = 1'h0;
    cs_n = 1'h1;
    wdog_fail = 1'h0;
    ext_rst_n = 1'h1;
    mp_in = 4'h0;
    faults = '0;
    watchdog_config_input = 2'h2;
    ctrl = '0;
    ctrl.sensor_supply_on = 1'h1;
    repeat (2) @(negedge clk);
    rst = 1'h0;
    t_normal();
    t_timeout(2'h1, omc_pkg::ST_RESET);
    t_timeout(2'h2, omc_pkg::ST_NORM);
    t_sleep();
    t_stop();
    end_sim();
  end
  // all scenarios together need well under this span
  initial
  begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end
endmodule
bind omc_mode_ctrl omc_mode_ctrl_props #(.RST_PULSE_CYC(RST_PULSE_CYC),
  .NREQ_TMO_CYC(NREQ_TMO_CYC)) u_props (.clk, .rst, .mode_control_reg_wr,
  .mode_select_bits, .vdd_low, .wdog_fail, .watchdog_config_input, .mode, .outs, .rst_out_n);
`default_nettype wire
